//--- core/kbd_matrix_scanner.sv
`timescale 1ns/1ps
module keyboard_matrix_scanner #(
  parameter int unsigned REPEAT_CYC = kbd_scan_pkg::REPEAT_US * kbd_scan_pkg::CLK_MHZ,
  parameter int unsigned SCAN_STEP_CYC = kbd_scan_pkg::STEP_CYC,
  parameter int unsigned SENSE_MIN_CYC = kbd_scan_pkg::MIN_PULSE_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic key_sense_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic we_in,
  input wire logic re_in,
  output logic [31:0] rdata_out,
  output logic [15:0] column_select_out,
  output logic [3:0] row_select_out,
  output logic threshold_feedback_out,
  output logic [7:0] key_code_out,
  output logic ready_strobe_out,
  output logic key_active_out,
  output logic local_out,
  output logic reset_request_out,
  output logic break_request_out,
  output logic irq_out
);

  localparam int CW = kbd_scan_pkg::CNT_W;
  localparam int SW = kbd_scan_pkg::ST_W;
  // Step and sense lengths may be shortened together for fast simulation
  localparam logic [CW-1:0] STEP_LAST = CW'(SCAN_STEP_CYC - 1);
  localparam logic [CW-1:0] SENSE_MIN = CW'(SENSE_MIN_CYC);

  typedef struct packed {
    kbd_scan_pkg::seq_state_t seq;
    logic [7:0] pos;
    logic [7:0] addr;
    logic [CW-1:0] step_cnt;
    logic [CW-1:0] sense_cnt;
    logic [15:0] col_sel;
    logic [7:0] func_acc;
    logic [7:0] func;
    logic [7:0] code;
    logic strobe;
    logic [CW-1:0] strobe_cnt;
    logic key_active;
    logic thr;
    logic [SW-1:0] status;
    logic [SW-1:0] mask;
    logic scan_en;
    logic [31:0] rdata;
    logic irq;
  } scan_state_t;

  scan_state_t st_q;
  scan_state_t st_d;

  logic step;
  logic hit;
  logic load;
  logic at_addr;
  logic func_col;
  logic [3:0] rom_nib;
  logic rep_strobe;
  logic rep_active;
  logic [SW-1:0] events;
  logic [SW-1:0] clr;

  // ----------------------------------------------------------------
  // Encoding ROM and repeat counter
  // ----------------------------------------------------------------
  kbd_encode_rom u_rom (
    .column_in(st_q.pos[7:4]),
    .shift_in(st_q.func[kbd_scan_pkg::FN_SHIFT] | st_q.func[kbd_scan_pkg::FN_SHIFT_LOCK]),
    .upper_in(st_q.func[kbd_scan_pkg::FN_UPPER]),
    .control_in(st_q.func[kbd_scan_pkg::FN_CONTROL]),
    .nibble_out(rom_nib)
  );

  // Repeat only while a character key is held with the repeat key
  kbd_repeat_counter #(
    .PERIOD_CYC(REPEAT_CYC)
  ) u_rep (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .enable_in(st_q.func[kbd_scan_pkg::FN_REPEAT] & st_q.key_active),
    .repeat_strobe_out(rep_strobe),
    .repeating_out(rep_active)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    load = 1'b0;
    events = '0;
    clr = '0;
    step = st_q.scan_en && (st_q.step_cnt == STEP_LAST);
    // Short noise never passes the count
    hit = step && (st_q.sense_cnt > SENSE_MIN);
    at_addr = (st_q.pos == st_q.addr);
    func_col = (st_q.pos[7:4] == kbd_scan_pkg::FUNC_COL);

    if (st_q.scan_en) begin
      st_d.step_cnt = step ? '0 : st_q.step_cnt + 1'b1;
      st_d.sense_cnt = step ? '0 : st_q.sense_cnt + CW'(key_sense_in);
    end

    if (step) begin
      // Row is the low nibble, so rows finish before the column moves
      st_d.pos = st_q.pos + 8'h01;
      st_d.col_sel = 16'h0001 << st_d.pos[7:4];
      if (func_col) begin
        if (!st_q.pos[3]) begin
          st_d.func_acc[st_q.pos[2:0]] = hit;
        end
        if (st_q.pos[3:0] == kbd_scan_pkg::LAST_ROW) begin
          st_d.func = st_q.func_acc;
          events[kbd_scan_pkg::ST_FUNC] = (st_q.func_acc != st_q.func);
        end
      end else begin
        case (st_q.seq)
          kbd_scan_pkg::SEEK: begin
            if (hit) begin
              st_d.addr = st_q.pos;
              st_d.seq = kbd_scan_pkg::ARMED;
              st_d.thr = 1'b0;
            end
          end
          kbd_scan_pkg::ARMED: begin
            // Other addresses wait, so closures are taken in order
            if (at_addr && hit) begin
              st_d.seq = kbd_scan_pkg::HELD;
              st_d.key_active = 1'b1;
              load = !rep_active;
            end else if (at_addr) begin
              st_d.seq = kbd_scan_pkg::SEEK;
              st_d.thr = 1'b1;
            end
          end
          kbd_scan_pkg::HELD: begin
            if (at_addr && !hit) begin
              st_d.seq = kbd_scan_pkg::SEEK;
              st_d.key_active = 1'b0;
              st_d.thr = 1'b1;
            end
          end
          default: begin
            st_d.seq = kbd_scan_pkg::SEEK;
            st_d.thr = 1'b1;
          end
        endcase
      end
    end

    if (load) begin
      st_d.code = {rom_nib, st_q.pos[3:0]};
      events[kbd_scan_pkg::ST_LOAD] = 1'b1;
    end
    events[kbd_scan_pkg::ST_REPEAT] = rep_strobe;

    // Strobe generator, restarted by a load or a repeat
    if (load || rep_strobe) begin
      st_d.strobe = 1'b1;
      st_d.strobe_cnt = '0;
    end else if (st_q.strobe) begin
      st_d.strobe_cnt = st_q.strobe_cnt + 1'b1;
      if (st_q.strobe_cnt == kbd_scan_pkg::STROBE_CYC - 1'b1) begin
        st_d.strobe = 1'b0;
      end
    end

    // Register writes
    if (we_in) begin
      case (addr_in)
        kbd_scan_pkg::OFF_STATUS: clr = wdata_in[SW-1:0];
        kbd_scan_pkg::OFF_MASK: st_d.mask = wdata_in[SW-1:0];
        kbd_scan_pkg::OFF_CTRL: st_d.scan_en = wdata_in[kbd_scan_pkg::CTRL_SCAN_EN];
        default: begin
        end
      endcase
    end
    // A new event beats a clear in the same cycle
    st_d.status = (st_q.status & ~clr) | events;
    st_d.irq = |(st_d.status & st_d.mask);

    // Register reads, data valid one cycle later only
    st_d.rdata = 32'h0;
    if (re_in) begin
      case (addr_in)
        kbd_scan_pkg::OFF_KEY_PORT_READ: st_d.rdata = {24'h0, st_q.code};
        kbd_scan_pkg::OFF_STATUS: st_d.rdata = {29'h0, st_q.status};
        kbd_scan_pkg::OFF_MASK: st_d.rdata = {29'h0, st_q.mask};
        kbd_scan_pkg::OFF_CTRL: st_d.rdata = {31'h0, st_q.scan_en};
        kbd_scan_pkg::OFF_FUNC: st_d.rdata = {24'h0, st_q.func};
        default: st_d.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.seq <= kbd_scan_pkg::SEEK;
      st_q.col_sel <= kbd_scan_pkg::RST_COL_SEL;
      st_q.code <= kbd_scan_pkg::RST_CODE;
      st_q.thr <= 1'b1;
      st_q.mask <= kbd_scan_pkg::RST_MASK;
      st_q.scan_en <= kbd_scan_pkg::RST_SCAN_EN;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out = st_q.rdata;
  assign column_select_out = st_q.col_sel;
  assign row_select_out = st_q.pos[3:0];
  assign threshold_feedback_out = st_q.thr;
  assign key_code_out = st_q.code;
  assign ready_strobe_out = st_q.strobe;
  assign key_active_out = st_q.key_active;
  // Function outputs go straight to the host connector
  assign local_out = st_q.func[kbd_scan_pkg::FN_LOCAL];
  assign reset_request_out = st_q.func[kbd_scan_pkg::FN_RESET];
  assign break_request_out = st_q.func[kbd_scan_pkg::FN_BREAK];
  assign irq_out = st_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CW-1:0] high_cnt;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      high_cnt <= '0;
    end else begin
      // A restart stretches the strobe, so the length count starts over
      if (load || rep_strobe) begin
        high_cnt <= '0;
      end else begin
        high_cnt <= ready_strobe_out ? high_cnt + 1'b1 : '0;
      end
    end
  end

  property p_col_onehot;
    @(posedge clock_in) disable iff (rst_in) $onehot(column_select_out);
  endproperty
  a_col_onehot: assert property (p_col_onehot) else $error("column select not one-hot");

  property p_rows_first;
    @(posedge clock_in) disable iff (rst_in)
    $changed(column_select_out) |-> $past(row_select_out) == kbd_scan_pkg::LAST_ROW && row_select_out == 4'h0;
  endproperty
  a_rows_first: assert property (p_rows_first) else $error("column moved before last row");

  property p_accept_twice;
    @(posedge clock_in) disable iff (rst_in)
    load |-> st_q.seq == kbd_scan_pkg::ARMED && at_addr && hit;
  endproperty
  a_accept_twice: assert property (p_accept_twice) else $error("load without second detection");

  property p_load_code;
    @(posedge clock_in) disable iff (rst_in)
    load |=> key_code_out == {$past(rom_nib), $past(row_select_out)};
  endproperty
  a_load_code: assert property (p_load_code) else $error("latched code wrong");

  property p_thr_low;
    @(posedge clock_in) disable iff (rst_in)
    load |=> !threshold_feedback_out && key_active_out;
  endproperty
  a_thr_low: assert property (p_thr_low) else $error("threshold not lowered on closure");

  property p_thr_idle;
    @(posedge clock_in) disable iff (rst_in)
    st_q.seq == kbd_scan_pkg::SEEK |-> threshold_feedback_out && !key_active_out;
  endproperty
  a_thr_idle: assert property (p_thr_idle) else $error("threshold low while idle");

  property p_strobe_len;
    @(posedge clock_in) disable iff (rst_in)
    $fell(ready_strobe_out) |-> high_cnt == kbd_scan_pkg::STROBE_CYC;
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("ready strobe length wrong");

  property p_rep_no_load;
    @(posedge clock_in) disable iff (rst_in)
    rep_active |-> !load;
  endproperty
  a_rep_no_load: assert property (p_rep_no_load) else $error("load while repeating");

  property p_rep_strobe;
    @(posedge clock_in) disable iff (rst_in)
    rep_strobe |=> ready_strobe_out && $stable(key_code_out);
  endproperty
  a_rep_strobe: assert property (p_rep_strobe) else $error("repeat did not re-fire strobe");

  property p_func_col;
    @(posedge clock_in) disable iff (rst_in)
    $changed(st_q.func) |-> $past(st_q.pos) == {kbd_scan_pkg::FUNC_COL, kbd_scan_pkg::LAST_ROW};
  endproperty
  a_func_col: assert property (p_func_col) else $error("function latch outside its column");

  property p_code_hold;
    @(posedge clock_in) disable iff (rst_in)
    !$past(load) |-> $stable(key_code_out);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("key code changed without load");

  property p_short_pulse;
    @(posedge clock_in) disable iff (rst_in)
    step && st_q.sense_cnt <= SENSE_MIN |-> !hit && !load;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse accepted");

  c_load: cover property (@(posedge clock_in) disable iff (rst_in) load);
  c_repeat: cover property (@(posedge clock_in) disable iff (rst_in) rep_strobe);
  c_release: cover property (@(posedge clock_in) disable iff (rst_in) $fell(key_active_out));
  c_func: cover property (@(posedge clock_in) disable iff (rst_in) $changed(st_q.func));

endmodule // keyboard_matrix_scanner

//--- core/kbd_scan_pkg.sv
package kbd_scan_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int STEP_NS = 6000;
  localparam int MIN_PULSE_NS = 1500;
  localparam int STROBE_NS = 6000;
  localparam int REPEAT_US = 50000;
  localparam int CNT_W = 11;
  localparam int REP_W = 24;
  localparam logic [CNT_W-1:0] STEP_CYC = CNT_W'(STEP_NS * CLK_MHZ / 1000);
  localparam logic [CNT_W-1:0] MIN_PULSE_CYC = CNT_W'((MIN_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(STROBE_NS * CLK_MHZ / 1000);

  // ----------------------------------------------------------------
  // Matrix layout
  // ----------------------------------------------------------------
  localparam logic [3:0] FUNC_COL = 4'hf;
  localparam logic [3:0] LAST_ROW = 4'hf;
  localparam logic [3:0] SPECIAL_COL = 4'h6;
  localparam logic [3:0] ASCII_BASE = 4'h2;
  localparam int FN_SHIFT = 0;
  localparam int FN_SHIFT_LOCK = 1;
  localparam int FN_UPPER = 2;
  localparam int FN_CONTROL = 3;
  localparam int FN_LOCAL = 4;
  localparam int FN_RESET = 5;
  localparam int FN_BREAK = 6;
  localparam int FN_REPEAT = 7;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_KEY_PORT_READ = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_FUNC = 8'h10;
  localparam int ST_W = 3;
  localparam int ST_LOAD = 0;
  localparam int ST_REPEAT = 1;
  localparam int ST_FUNC = 2;
  localparam int CTRL_SCAN_EN = 0;
  localparam logic [ST_W-1:0] RST_MASK = 3'h0;
  localparam logic RST_SCAN_EN = 1'b1;
  localparam logic [15:0] RST_COL_SEL = 16'h0001;
  localparam logic [7:0] RST_CODE = 8'h00;

  typedef enum logic [2:0] {
    SEEK = 3'b001,
    ARMED = 3'b010,
    HELD = 3'b100
  } seq_state_t;

endpackage

//--- core/kbd_encode_rom.sv
`timescale 1ns/1ps
module kbd_encode_rom (
  input wire logic [3:0] column_in,
  input wire logic shift_in,
  input wire logic upper_in,
  input wire logic control_in,
  output logic [3:0] nibble_out
);

  logic [3:0] base;
  logic key_code_special_bit;

  // ----------------------------------------------------------------
  // Seven address bits: column plus three function bits
  // ----------------------------------------------------------------
  always_comb begin
    base = 4'(column_in + kbd_scan_pkg::ASCII_BASE);
    key_code_special_bit = (column_in >= kbd_scan_pkg::SPECIAL_COL);
    if (key_code_special_bit) begin
      nibble_out = {1'b1, 3'(column_in - kbd_scan_pkg::SPECIAL_COL)};
    end else begin
      nibble_out = base;
      // Lower-case rows fold onto capitals
      if ((shift_in || upper_in) && base[2] && base[1]) begin
        nibble_out[1] = 1'b0;
      end else if (shift_in && !base[2]) begin
        nibble_out[0] = ~base[0];
      end
      if (control_in && base[2]) begin
        nibble_out[2:1] = 2'h0;
      end
    end
  end

endmodule // kbd_encode_rom

//--- core/kbd_repeat_counter.sv
`timescale 1ns/1ps
module kbd_repeat_counter #(
  parameter int unsigned PERIOD_CYC = kbd_scan_pkg::REPEAT_US * kbd_scan_pkg::CLK_MHZ
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic enable_in,
  output logic repeat_strobe_out,
  output logic repeating_out
);

  typedef struct packed {
    logic [kbd_scan_pkg::REP_W-1:0] cnt;
    logic pulse;
    logic active;
  } rep_state_t;

  rep_state_t st_q;
  rep_state_t st_d;

  localparam int RW = kbd_scan_pkg::REP_W;
  localparam logic [RW-1:0] LAST = RW'(PERIOD_CYC - 1);

  always_comb begin
    st_d = st_q;
    st_d.pulse = 1'b0;
    st_d.active = enable_in;
    if (!enable_in) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == LAST) begin
      st_d.cnt = '0;
      st_d.pulse = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign repeat_strobe_out = st_q.pulse;
  assign repeating_out = st_q.active;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rep_needs_enable;
    @(posedge clock_in) disable iff (rst_in)
    repeat_strobe_out |-> $past(enable_in) && repeating_out;
  endproperty
  a_rep_needs_enable: assert property (p_rep_needs_enable) else $error("repeat strobe without enable");

endmodule // kbd_repeat_counter

//--- bench/host_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the register port
// ----------------------------------------------------------------
module host_cpu_model (
  input wire logic clock_in,
  input wire logic [31:0] rdata_in,
  output logic [7:0] addr_out,
  output logic [31:0] wdata_out,
  output logic we_out,
  output logic re_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 32'h0;
    we_out = 1'b0;
    re_out = 1'b0;
  end

  // Idle lines inverted so a stale address never looks valid
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wdata_out <= d;
    we_out <= 1'b1;
    @(posedge clock_in);
    we_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [31:0] q);
    @(posedge clock_in);
    addr_out <= a;
    re_out <= 1'b1;
    @(posedge clock_in);
    re_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clock_in);
    q = rdata_in;
  endtask
endmodule // host_cpu_model

//--- bench/testbench.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module testbench;
  // Short scan step keeps two matrix passes well inside the run
  localparam int STEP = 100;
  localparam int MIN = 25;
  localparam int STROBE = kbd_scan_pkg::STROBE_CYC;
  localparam int REP = 3000;
  localparam int KEY_STEP = 1;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic key_sense_in = 1'b0;
  logic [7:0] addr_in;
  logic [31:0] wdata_in;
  logic we_in;
  logic re_in;
  logic [31:0] rdata_out;
  logic [15:0] column_select_out;
  logic [3:0] row_select_out;
  logic threshold_feedback_out;
  logic [7:0] key_code_out;
  logic ready_strobe_out;
  logic key_active_out;
  logic local_out;
  logic reset_request_out;
  logic break_request_out;
  logic irq_out;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int off = 0;
  int len = 0;
  int width = 0;
  int pulses = 0;
  int exp_code;
  int exp_q[$];
  logic [31:0] q;

  always #2.5 clock_in = ~clock_in;

  keyboard_matrix_scanner #(.REPEAT_CYC(REP), .SCAN_STEP_CYC(STEP), .SENSE_MIN_CYC(MIN)) uut (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .key_sense_in(key_sense_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .we_in(we_in),
    .re_in(re_in),
    .rdata_out(rdata_out),
    .column_select_out(column_select_out),
    .row_select_out(row_select_out),
    .threshold_feedback_out(threshold_feedback_out),
    .key_code_out(key_code_out),
    .ready_strobe_out(ready_strobe_out),
    .key_active_out(key_active_out),
    .local_out(local_out),
    .reset_request_out(reset_request_out),
    .break_request_out(break_request_out),
    .irq_out(irq_out)
  );

  host_cpu_model host (
    .clock_in(clock_in),
    .rdata_in(rdata_out),
    .addr_out(addr_in),
    .wdata_out(wdata_in),
    .we_out(we_in),
    .re_out(re_in)
  );

  // ----------------------------------------------------------------
  // Sense circuit model and scan position reference
  // ----------------------------------------------------------------
  // Noise steps stay at or under MIN high cycles, never a hit
  function automatic int press_len(input int k);
    if (k == 0) return MIN;
    if (k == KEY_STEP || k == 256 + KEY_STEP) return MIN + 10;
    if (k == 244 || k == 246 || k == 247) return MIN + 30;
    return $urandom_range(MIN);
  endfunction

  always @(posedge clock_in) begin
    if (rst_in) cyc <= 0;
    else cyc <= cyc + 1;
  end

  // Pulse kept mid-step so a one-cycle step skew does not matter
  always @(posedge clock_in) begin
    off = cyc % STEP;
    if (off == 0) len = press_len(cyc / STEP);
    if (off == 0 && cyc / STEP == 256 + KEY_STEP) exp_q.push_back(exp_code);
    key_sense_in <= !rst_in && off >= 20 && off < 20 + len;
    if (!rst_in && off == 90) begin
      `CHECK(column_select_out, 16'h0001 << ((cyc / STEP) / 16 % 16))
      `CHECK(row_select_out, 4'((cyc / STEP) % 16))
    end
  end

  always @(posedge clock_in) begin
    if (rst_in) width <= 0;
    else if (ready_strobe_out) begin
      if (width == 0) begin
        `CHECK(exp_q.size() > 0, 1'b1)
        if (exp_q.size() > 0) `CHECK(key_code_out, 8'(exp_q[$]))
      end
      width <= width + 1;
    end else if (width > 0) begin
      `CHECK(width, STROBE)
      pulses <= pulses + 1;
      width <= 0;
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  task automatic wait_cyc(input int n);
    while (cyc < n) @(posedge clock_in);
    #1;
  endtask

  task automatic close_out();
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock_in);
    err_total++;
    close_out();
  end

  initial begin
    void'($urandom(32'h17423395));
    exp_code = ((KEY_STEP / 16 + 2) << 4) | (KEY_STEP % 16);
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    host.read_reg(8'h08, q);
    `CHECK(q, 32'h0)
    host.read_reg(8'h0c, q);
    `CHECK(q, 32'h1)
    host.read_reg(8'h14, q);
    `CHECK(q, 32'h0)
    host.read_reg(8'h00, q);
    `CHECK(q, 32'h0)
    wait_cyc(STEP + 60);
    `CHECK(threshold_feedback_out, 1'b1)
    wait_cyc(2 * STEP + 60);
    `CHECK(threshold_feedback_out, 1'b0)
    `CHECK(key_active_out, 1'b0)
    wait_cyc(256 * STEP + 60);
    `CHECK(local_out, 1'b1)
    `CHECK(break_request_out, 1'b1)
    `CHECK(reset_request_out, 1'b0)
    `CHECK(irq_out, 1'b0)
    host.read_reg(8'h10, q);
    `CHECK(q, 32'hd0)
    wait_cyc(258 * STEP + 20);
    `CHECK(key_code_out, 8'(exp_code))
    `CHECK(ready_strobe_out, 1'b1)
    `CHECK(key_active_out, 1'b1)
    `CHECK(threshold_feedback_out, 1'b0)
    // Key port is read-only: the write must leave the code alone
    host.write_reg(8'h00, 32'hff);
    host.read_reg(8'h00, q);
    `CHECK(q, 32'(exp_code))
    wait_cyc(258 * STEP + 7500);
    `CHECK(pulses, 3)
    `CHECK(key_code_out, 8'(exp_code))
    host.read_reg(8'h04, q);
    `CHECK(q, 32'h7)
    host.write_reg(8'h08, 32'h1);
    repeat (2) @(posedge clock_in);
    `CHECK(irq_out, 1'b1)
    host.write_reg(8'h04, 32'h1);
    host.read_reg(8'h04, q);
    `CHECK(q, 32'h6)
    `CHECK(irq_out, 1'b0)
    // Held address scanned again with no hit releases the key
    wait_cyc(514 * STEP + 60);
    `CHECK(key_active_out, 1'b0)
    `CHECK(threshold_feedback_out, 1'b1)
    `CHECK(local_out, 1'b0)
    `CHECK(pulses, 9)
    `CHECK(key_code_out, 8'(exp_code))
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    #1;
    `CHECK(column_select_out, 16'h0001)
    `CHECK(key_code_out, 8'h00)
    `CHECK(key_active_out, 1'b0)
    `CHECK(ready_strobe_out, 1'b0)
    `CHECK(threshold_feedback_out, 1'b1)
    `CHECK(local_out, 1'b0)
    `CHECK(irq_out, 1'b0)
    close_out();
  end
endmodule // testbench
